// [design/acc_calib_ctrl.sv]
// Purpose: Register file and sequencing for the converter calibration engine.
// Assumes: AXI4-Lite slave, one write and one read outstanding at most.
// Notes:   Status bits clear on every start, but stopped is set when no calibration is enabled; the engine runs on the config latched then.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module acc_calib_ctrl
    import acc_pkg::*;
#(
    parameter logic [CNT_W-1:0] FG_CYCLES = FG_CAL_CYCLES
)
(
    input  wire logic              clock_i,
    input  wire logic              arst_n_i,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [AXI_AW-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              wvalid,
    output logic                   wready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    output logic                   bvalid,
    input  wire logic              bready,
    output logic      [1:0]        bresp,
    input  wire logic              arvalid,
    output logic                   arready,
    input  wire logic [AXI_AW-1:0] araddr,
    input  wire logic [2:0]        arprot,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic      [31:0]       rdata,
    output logic      [1:0]        rresp,
    input  wire logic              calib_trigger_pin_i,
    input  wire logic              alarm_i,
    output logic                   calib_status_pin_o,
    output logic                   engine_reset_o,
    output logic                   divider_reset_o,
    output acc_engine_t            engine_o
);
    typedef struct packed {
        logic             aw_got;
        logic [9:0]       aw_idx;
        logic             aw_ok;
        logic             w_got;
        logic [7:0]       w_byte;
        logic             w_lane0;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [7:0]       rdata;
        logic [1:0]       rresp;
        logic             cal_en;
        acc_cfg_t         cfg;
        logic [1:0]       stat_sel;
        logic             trig_src;
        logic             soft_trig;
        acc_cfg_t         run_cfg;
        acc_fsm_t         fsm;
        logic [CNT_W-1:0] cnt;
        logic             foreground_complete_flag;
        logic             stopped;
        logic             stat_pin;
        acc_engine_t      eng;
    } acc_state_t;

    acc_state_t s_reg;
    acc_state_t s_next;
    logic [1:0] pin_sync;
    logic       trigger;

    // Word index of an aligned address, with a flag for mapped registers.
    function automatic logic [10:0] reg_decode(input logic [AXI_AW-1:0] addr);
        logic [9:0] idx;
        logic       hit;
        idx = addr[AXI_AW-1:2];
        hit = (addr[1:0] == 2'h0) &&
              (idx == IDX_CAL_ENABLE || idx == IDX_CAL_CONFIG || idx == IDX_CAL_STATE ||
               idx == IDX_CAL_PIN || idx == IDX_CAL_SOFTTRG);
        return {hit, idx};
    endfunction

    // Pins come from outside the clock domain.
    acc_sync3 u_sync (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .pins_i   ({alarm_i, calib_trigger_pin_i}),
        .pins_o   (pin_sync)
    );

    // Trigger comes from the pin or the software bit, never both.
    assign trigger = s_reg.trig_src ? pin_sync[0] : s_reg.soft_trig;

    // Ready terms hold off new requests until the pending answer is taken.
    assign awready = !s_reg.aw_got && !s_reg.bvalid;
    assign wready  = !s_reg.w_got && !s_reg.bvalid;
    assign arready = !s_reg.rvalid;

    // Bus, registers and calibration sequence in one next-state process.
    always_comb begin
        logic [10:0] dec;
        logic [10:0] rdec;
        s_next = s_reg;
        dec    = '0;
        rdec   = '0;

        // Address and data are taken in either order.
        if (awvalid && awready) begin
            dec           = reg_decode(awaddr);
            s_next.aw_got = 1'b1;
            s_next.aw_idx = dec[9:0];
            s_next.aw_ok  = dec[10];
        end
        // Only lane 0 carries a register byte; the other lanes are ignored.
        if (wvalid && wready) begin
            s_next.w_got   = 1'b1;
            s_next.w_byte  = wdata[7:0];
            s_next.w_lane0 = wstrb[0];
        end

        // Perform the write once both halves are held.
        if (s_reg.aw_got && s_reg.w_got) begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = s_reg.aw_ok ? RESP_OKAY : RESP_SLVERR;
            if (s_reg.aw_ok && s_reg.w_lane0) begin
                unique case (s_reg.aw_idx)
                    IDX_CAL_ENABLE: begin
                        s_next.cal_en = s_reg.w_byte[POS_RUN];
                    end
                    IDX_CAL_CONFIG: begin
                        // Accepted at any time; changes only act at the next start.
                        s_next.cfg = acc_cfg_t'(s_reg.w_byte[4:0]);
                    end
                    IDX_CAL_PIN: begin
                        s_next.trig_src = s_reg.w_byte[POS_TRIG_SRC];
                        s_next.stat_sel = s_reg.w_byte[POS_STAT_SEL+:2];
                    end
                    IDX_CAL_SOFTTRG: begin
                        s_next.soft_trig = s_reg.w_byte[POS_SOFT_TRIG];
                    end
                    default: begin
                        // The status register is read-only; the write is answered and dropped.
                    end
                endcase
            end
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end

        // Reads answer one edge after the address is taken.
        if (arvalid && arready) begin
            rdec          = reg_decode(araddr);
            s_next.rvalid = 1'b1;
            s_next.rresp  = rdec[10] ? RESP_OKAY : RESP_SLVERR;
            s_next.rdata  = 8'h00;
            if (rdec[10]) begin
                unique case (rdec[9:0])
                    IDX_CAL_ENABLE:  s_next.rdata = {7'h00, s_reg.cal_en};
                    IDX_CAL_CONFIG:  s_next.rdata = {3'h0, s_reg.cfg};
                    IDX_CAL_STATE:   s_next.rdata = {6'h00, s_reg.stopped, s_reg.foreground_complete_flag};
                    IDX_CAL_PIN:     s_next.rdata = {5'h00, s_reg.stat_sel, s_reg.trig_src};
                    IDX_CAL_SOFTTRG: s_next.rdata = {7'h00, s_reg.soft_trig};
                    default:         s_next.rdata = 8'h00;
                endcase
            end
        end else if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end

        // Calibration sequence.
        s_next.eng.values_clear = 1'b0;
        if (!s_reg.cal_en) begin
            s_next.fsm = ST_HOLD;
            s_next.cnt = '0;
        end else begin
            unique case (s_reg.fsm)
                ST_HOLD: begin
                    // A start latches the configuration, clears the completion bit and clears stopped unless neither calibration is enabled.
                    s_next.run_cfg          = s_reg.cfg;
                    s_next.foreground_complete_flag          = 1'b0;
                    s_next.stopped          = 1'b0;
                    s_next.eng.values_clear = 1'b1;
                    s_next.cnt              = '0;
                    if (s_reg.cfg.foreground_calib_run) begin
                        s_next.fsm = ST_FG;
                    end else if (s_reg.cfg.background_calib_enable) begin
                        s_next.fsm = ST_BG;
                    end else begin
                        s_next.fsm     = ST_DONE;
                        s_next.stopped = 1'b1;
                    end
                end
                ST_FG: begin
                    // Foreground only advances while the trigger is high.
                    if (trigger) begin
                        if (s_reg.cnt == FG_CYCLES - 1'b1) begin
                            s_next.foreground_complete_flag = 1'b1;
                            s_next.cnt     = '0;
                            if (s_reg.run_cfg.background_calib_enable) begin
                                s_next.fsm = ST_BG;
                            end else begin
                                s_next.fsm     = ST_DONE;
                                s_next.stopped = 1'b1;
                            end
                        end else begin
                            s_next.cnt = s_reg.cnt + 1'b1;
                        end
                    end
                end
                ST_BG: begin
                    // A low trigger asks background calibration to pause.
                    if (!trigger) begin
                        s_next.fsm     = ST_STOP;
                        s_next.stopped = 1'b1;
                    end
                end
                ST_STOP: begin
                    if (trigger) begin
                        s_next.fsm     = ST_BG;
                        s_next.stopped = 1'b0;
                    end
                end
                ST_DONE: begin
                    // Parked until the run bit is cleared; both status bits hold.
                end
            endcase
        end

        // Engine drive follows the next state so that it lines up with it.
        s_next.eng.fg_run        = (s_next.fsm == ST_FG);
        s_next.eng.bg_run        = (s_next.fsm == ST_BG);
        s_next.eng.fg_offset     = (s_next.fsm == ST_FG) &&
                                   s_next.run_cfg.foreground_offset_calib_enable;
        s_next.eng.bg_offset     = (s_next.fsm == ST_BG) && s_next.run_cfg.background_calib_enable &&
                                   s_next.run_cfg.background_offset_calib_enable;
        s_next.eng.offset_filter = (s_next.fsm != ST_HOLD) &&
                                   s_next.run_cfg.offset_filter_enable;

        // Status pin source; the reserved code drives low like code three.
        unique case (s_reg.stat_sel)
            SEL_FOREGROUND_COMPLETE_FLAG: s_next.stat_pin = s_reg.foreground_complete_flag;
            SEL_ALARM:   s_next.stat_pin = pin_sync[1];
            default:     s_next.stat_pin = 1'b0;
        endcase
    end

    // State register; the status bits have no documented reset but start cleared.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg           <= '0;
            s_reg.cal_en    <= RST_RUN;
            s_reg.cfg       <= acc_cfg_t'(RST_CONFIG);
            s_reg.run_cfg   <= acc_cfg_t'(RST_CONFIG);
            s_reg.stat_sel  <= RST_STAT_SEL;
            s_reg.trig_src  <= RST_TRIG_SRC;
            s_reg.soft_trig <= RST_SOFT_TRIG;
            s_reg.fsm       <= ST_HOLD;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs; the engine and divider resets are levels held while the run bit is low.
    assign bvalid             = s_reg.bvalid;
    assign bresp              = s_reg.bresp;
    assign rvalid             = s_reg.rvalid;
    assign rdata              = {24'h000000, s_reg.rdata};
    assign rresp              = s_reg.rresp;
    assign engine_reset_o     = !s_reg.cal_en;
    assign divider_reset_o    = !s_reg.cal_en;
    assign calib_status_pin_o = s_reg.stat_pin;
    assign engine_o           = s_reg.eng;

    // Checks watch registered state; they are off while reset is held.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    chk_hold_engine: assert property (!s_reg.cal_en |=> s_reg.fsm == ST_HOLD && !engine_o.fg_run)
        else $error("Engine not held while run bit low.");
    chk_div_reset: assert property ($fell(s_reg.cal_en) |-> divider_reset_o && engine_reset_o)
        else $error("Dividers not reset when run bit cleared.");
    chk_filter_latch: assert property ($rose(s_reg.cal_en) |=> ##1
        engine_o.offset_filter == $past(s_reg.cfg.offset_filter_enable, 2))
        else $error("Offset filter not taken from latched config.");
    chk_bg_offset: assert property (engine_o.bg_offset |-> engine_o.bg_run && s_reg.run_cfg.background_calib_enable)
        else $error("Background offset active without background run.");
    chk_fg_offset: assert property (engine_o.fg_offset |-> s_reg.fsm == ST_FG)
        else $error("Foreground offset active outside foreground.");
    chk_bg_enable: assert property (s_reg.fsm == ST_BG |-> s_reg.run_cfg.background_calib_enable)
        else $error("Background runs while disabled.");
    chk_fg_skip: assert property (s_reg.fsm == ST_HOLD && s_reg.cal_en && !s_reg.cfg.foreground_calib_run
        |=> s_reg.fsm != ST_FG && engine_o.values_clear)
        else $error("Foreground not skipped or values not cleared.");
    chk_stop_flag: assert property (s_reg.fsm == ST_BG && s_reg.cal_en && !trigger |=> s_reg.stopped ##1
        (s_reg.stopped || s_reg.fsm != ST_STOP))
        else $error("Stopped bit not set at background stop.");
    chk_fg_end: assert property (s_reg.fsm == ST_FG && s_reg.cal_en && trigger && s_reg.cnt == FG_CYCLES - 1'b1
        |=> s_reg.foreground_complete_flag && (s_reg.stopped == !s_reg.run_cfg.background_calib_enable))
        else $error("Foreground completion not reported.");
    chk_status_pin: assert property (s_reg.stat_sel == 2'h3 |=> !calib_status_pin_o)
        else $error("Status pin not forced low.");
    chk_trig_src: assert property (s_reg.fsm == ST_FG && s_reg.cal_en && !s_reg.trig_src && !s_reg.soft_trig
        |=> $stable(s_reg.cnt))
        else $error("Foreground advanced without software trigger.");
    chk_start_clear: assert property (s_reg.fsm == ST_HOLD && s_reg.cal_en |=> !s_reg.foreground_complete_flag)
        else $error("Start did not clear status.");
    chk_resume_clear: assert property (s_reg.fsm == ST_STOP && s_reg.cal_en && trigger |=> !s_reg.stopped)
        else $error("Stopped bit not cleared on resume.");
    chk_pin_follow: assert property (s_reg.stat_sel == SEL_FOREGROUND_COMPLETE_FLAG
        |=> calib_status_pin_o == $past(s_reg.foreground_complete_flag))
        else $error("Status pin does not follow completion flag.");
    chk_soft_ignored: assert property (s_reg.fsm == ST_BG && s_reg.cal_en && s_reg.trig_src && pin_sync[0]
        |=> s_reg.fsm == ST_BG)
        else $error("Background paused although the selected pin is high.");
    chk_write_resp: assert property (s_reg.aw_got && s_reg.w_got |=> bvalid && !awready && !wready)
        else $error("Write not answered once both halves were held.");

    cov_foreground_complete_flag: cover property (s_reg.fsm == ST_FG ##1 s_reg.foreground_complete_flag);
    cov_bg_stop: cover property (s_reg.fsm == ST_BG ##1 s_reg.fsm == ST_STOP ##[1:50] s_reg.fsm == ST_BG);
    cov_restart: cover property ($fell(s_reg.cal_en) ##[1:100] $rose(s_reg.cal_en));
    cov_bad_addr: cover property (bvalid && bresp == RESP_SLVERR);
    cov_fg_stall: cover property (s_reg.fsm == ST_FG && !trigger ##1 s_reg.fsm == ST_FG);
endmodule
`default_nettype wire

// [design/acc_pkg.sv]
// Purpose: Shared constants and types for the converter calibration control block.
// Assumes: One 100 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes:   Printed register offsets are word indices; byte address is four times the index.
package acc_pkg;

    // Register indices as printed, and the AXI byte address width they are decoded from.
    localparam logic [9:0]  IDX_CAL_ENABLE  = 10'h061;
    localparam logic [9:0]  IDX_CAL_CONFIG  = 10'h062;
    localparam logic [9:0]  IDX_CAL_STATE   = 10'h06A;
    localparam logic [9:0]  IDX_CAL_PIN     = 10'h06B;
    localparam logic [9:0]  IDX_CAL_SOFTTRG = 10'h06C;
    localparam int          AXI_AW          = 12;

    // Field positions.
    localparam int          POS_RUN         = 0;
    localparam int          POS_FG          = 0;
    localparam int          POS_BG          = 1;
    localparam int          POS_FG_OS       = 2;
    localparam int          POS_BG_OS       = 3;
    localparam int          POS_OSFILT      = 4;
    localparam int          POS_STALL       = 0;
    localparam int          POS_STOPPED     = 1;
    localparam int          POS_TRIG_SRC    = 0;
    localparam int          POS_STAT_SEL    = 1;
    localparam int          POS_SOFT_TRIG   = 0;

    // Reset values.
    localparam logic        RST_RUN         = 1'b1;
    localparam logic [4:0]  RST_CONFIG      = 5'h01;
    localparam logic [1:0]  RST_STAT_SEL    = 2'h0;
    localparam logic        RST_TRIG_SRC    = 1'b0;
    localparam logic        RST_SOFT_TRIG   = 1'b1;

    // Status pin selections.
    localparam logic [1:0]  SEL_FOREGROUND_COMPLETE_FLAG     = 2'h0;
    localparam logic [1:0]  SEL_ALARM       = 2'h2;

    // AXI responses.
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Foreground calibration length.
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          FG_CAL_TIME_NS  = 1000;
    localparam int          CNT_W           = 16;
    localparam logic [CNT_W-1:0] FG_CAL_CYCLES = CNT_W'(FG_CAL_TIME_NS / CLK_PERIOD_NS);

    // Calibration configuration as stored.
    typedef struct packed {
        logic offset_filter_enable;
        logic background_offset_calib_enable;
        logic foreground_offset_calib_enable;
        logic background_calib_enable;
        logic foreground_calib_run;
    } acc_cfg_t;

    // Drive to the calibration engine.
    typedef struct packed {
        logic fg_run;
        logic bg_run;
        logic fg_offset;
        logic bg_offset;
        logic offset_filter;
        logic values_clear;
    } acc_engine_t;

    typedef enum logic [4:0] {
        ST_HOLD = 5'b00001,
        ST_FG   = 5'b00010,
        ST_BG   = 5'b00100,
        ST_STOP = 5'b01000,
        ST_DONE = 5'b10000
    } acc_fsm_t;

    // Synchroniser state for two pins.
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] level;
    } acc_sync_t;

endpackage

// [design/acc_sync3.sv]
// Purpose: Three-stage synchroniser with agreement filter for two pin inputs.
// Assumes: Pins are asynchronous to clock_i.
// Notes:   The output only follows once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module acc_sync3
    import acc_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       arst_n_i,
    input  wire logic [1:0] pins_i,
    output logic      [1:0] pins_o
);
    acc_sync_t s_reg;
    acc_sync_t s_next;

    // The first stage feeds only the second; the filter looks at stages two and three.
    always_comb begin
        s_next    = s_reg;
        s_next.s1 = pins_i;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        for (int i = 0; i < 2; i++) begin
            if (s_reg.s2[i] == s_reg.s3[i]) begin
                s_next.level[i] = s_reg.s3[i];
            end
        end
    end

    // State register.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pins_o = s_reg.level;
endmodule
`default_nettype wire

// [verification/acc_pin_drv.sv]
// Purpose: Far-side model of the trigger pin driver and the alarm source.
// Assumes: The bench sets the wanted levels; pins are asynchronous to the block.
// Notes:   Pins move 3 ns after the edge so their phase never matches the clock.
`timescale 1ns/1ps
`default_nettype none
module acc_pin_drv (
    input  wire logic clock_i,
    input  wire logic trig_level_i,
    input  wire logic alarm_level_i,
    output logic      calib_trigger_pin_o,
    output logic      alarm_o
);
    // Levels are re-timed off the edge to exercise the input synchroniser.
    always @(posedge clock_i) begin
        calib_trigger_pin_o <= #3 trig_level_i;
        alarm_o             <= #3 alarm_level_i;
    end
endmodule
`default_nettype wire

// [verification/adc_calibration_control_test.sv]
// Purpose: Register-level test of the calibration control block.
// Assumes: FG_CYCLES shortened to 4; AXI4-Lite master tasks below.
// Notes:   Waits are bounded by tick; a hang counts as a mismatch.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module adc_calibration_control_test;
    import acc_pkg::*;
    logic clock_i, arst_n_i, awvalid, wvalid, bready, arvalid, rready, trig_lv, alarm_lv;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata;
    logic awready, wready, bvalid, arready, rvalid, pin_o, eng_rst, div_rst, trig_pin, alarm;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    acc_engine_t eng;
    int fails = 0;
    int total_checks = 0;
    logic [7:0] d;
    logic [1:0] r;
    logic [3:0] strb;
    localparam logic [11:0] A_EN = 12'h184, A_CFG = 12'h188, A_ST = 12'h1A8;
    localparam logic [11:0] A_PIN = 12'h1AC, A_SW = 12'h1B0;
    acc_calib_ctrl #(.FG_CYCLES(16'h0004)) dut (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(strb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .calib_trigger_pin_i(trig_pin), .alarm_i(alarm),
        .calib_status_pin_o(pin_o), .engine_reset_o(eng_rst), .divider_reset_o(div_rst),
        .engine_o(eng));
    acc_pin_drv pins (.clock_i(clock_i), .trig_level_i(trig_lv), .alarm_level_i(alarm_lv),
        .calib_trigger_pin_o(trig_pin), .alarm_o(alarm));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // Single exit point so a timeout and a normal end report the same way.
    task automatic end_of_test();
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One clock with a hang guard; ready signals are sampled before the edge's updates land.
    task automatic tick(inout int n);
        @(posedge clock_i);
        n++;
        if (n > 200) begin
            fails++;
            end_of_test();
        end
    endtask
    // Address and data are offered together and each released once taken.
    task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
        int n;
        logic ad, dd;
        n = 0; ad = 0; dd = 0;
        @(posedge clock_i);
        awaddr <= a; wdata <= {24'h000000, v}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(ad && dd)) begin
            tick(n);
            if (awready && !ad) begin ad = 1; awvalid <= 1'b0; end
            if (wready && !dd) begin dd = 1; wvalid <= 1'b0; end
        end
        do tick(n); while (!bvalid);
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clock_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do tick(n); while (!arready);
        arvalid <= 1'b0;
        do tick(n); while (!rvalid);
        v = rdata[7:0];
        rs = rresp;
        rready <= 1'b0;
    endtask
    // Reads status until it shows the expected value or the bound runs out.
    task automatic poll(input logic [7:0] e);
        int k;
        for (k = 0; k < 40; k++) begin
            rd(A_ST, d, r);
            if (d === e) break;
        end
        `CHK(d, e)
    endtask
    task automatic pin_is(input logic e);
        int n;
        n = 0;
        while (pin_o !== e) tick(n);
        `CHK(pin_o, e)
    endtask
    initial begin
        logic [11:0] ra[4];
        logic [7:0] rv[4];
        ra = '{A_EN, A_CFG, A_PIN, A_SW};
        rv = '{8'h01, 8'h01, 8'h00, 8'h01};
        arst_n_i = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; trig_lv = 1; alarm_lv = 0;
        strb = 4'hF;
        repeat (20) @(posedge clock_i);
        arst_n_i <= 1'b1;
        // Register reset values, then an unmapped read.
        for (int i = 0; i < 4; i++) begin
            rd(ra[i], d, r);
            `CHK(d, rv[i])
        end
        rd(12'h000, d, r);
        `CHK(r, RESP_SLVERR)
        poll(8'h03);
        `CHK(eng_rst, 1'b0)
        wr(A_EN, 8'h00, RESP_OKAY);
        `CHK(eng_rst, 1'b1)
        `CHK(div_rst, 1'b1)
        wr(A_CFG, 8'h1F, RESP_OKAY);
        rd(A_CFG, d, r);
        `CHK(d, 8'h1F)
        // Lane 0 disabled: the write is answered but stores nothing.
        strb <= 4'h0;
        wr(A_CFG, 8'h00, RESP_OKAY);
        strb <= 4'hF;
        rd(A_CFG, d, r);
        `CHK(d, 8'h1F)
        wr(A_EN, 8'h01, RESP_OKAY);
        poll(8'h01);
        `CHK(eng.bg_run, 1'b1)
        `CHK(eng.bg_offset, 1'b1)
        `CHK(eng.offset_filter, 1'b1)
        // Software trigger low pauses background; high resumes it.
        wr(A_SW, 8'h00, RESP_OKAY);
        poll(8'h03);
        wr(A_SW, 8'h01, RESP_OKAY);
        poll(8'h01);
        // Hardware pin selected: the pin rules, the software bit is ignored.
        wr(A_PIN, 8'h01, RESP_OKAY);
        trig_lv <= 1'b0;
        poll(8'h03);
        trig_lv <= 1'b1;
        wr(A_SW, 8'h00, RESP_OKAY);
        poll(8'h01);
        wr(A_SW, 8'h01, RESP_OKAY);
        // Status pin sources.
        wr(A_PIN, 8'h00, RESP_OKAY);
        pin_is(1'b1);
        wr(A_PIN, 8'h04, RESP_OKAY);
        pin_is(1'b0);
        alarm_lv <= 1'b1;
        pin_is(1'b1);
        wr(A_PIN, 8'h06, RESP_OKAY);
        pin_is(1'b0);
        wr(A_PIN, 8'h04, RESP_OKAY);
        pin_is(1'b1);
        wr(A_PIN, 8'h02, RESP_OKAY);
        pin_is(1'b0);
        // Foreground skipped: stopped set without completion.
        wr(A_EN, 8'h00, RESP_OKAY);
        wr(A_CFG, 8'h00, RESP_OKAY);
        wr(A_EN, 8'h01, RESP_OKAY);
        poll(8'h02);
        wr(A_ST, 8'hFF, RESP_OKAY);
        rd(A_ST, d, r);
        `CHK(d, 8'h02)
        // Foreground with offset waits while the software trigger is low.
        wr(A_EN, 8'h00, RESP_OKAY);
        wr(A_CFG, 8'h05, RESP_OKAY);
        wr(A_SW, 8'h00, RESP_OKAY);
        wr(A_EN, 8'h01, RESP_OKAY);
        @(posedge clock_i);
        `CHK(eng.values_clear, 1'b1)
        repeat (10) @(posedge clock_i);
        `CHK(eng.fg_run, 1'b1)
        `CHK(eng.fg_offset, 1'b1)
        `CHK(eng.bg_offset, 1'b0)
        poll(8'h00);
        wr(A_SW, 8'h01, RESP_OKAY);
        poll(8'h03);
        `CHK(eng.fg_run, 1'b0)
        wr(12'h000, 8'h01, RESP_SLVERR);
        end_of_test();
    end
endmodule
`default_nettype wire
